// file: rtl/spt_top.sv
// Serial peripheral port with master and slave roles and both clock phases.
//
// Functional notes
// - As master the serial clock stays low for divisor plus one divided core clock periods.
// - As master the serial clock stays high for the same divisor plus one periods.
// - The divided core clock period is the undivided period times two to the divider field.
// - The undivided clock feeding the divider is the nominal PLL clock of about 48.8 ns.
// - Output data is valid within 2 undivided plus 2 divided periods (master) or 3 plus 2 (slave).
// - As master in phase 0 the first bit is driven half a low period before the first edge.
// - As slave in phase 0 the first bit is valid within 3 plus 2 periods of select going low.
`timescale 1ns/1ps
module spt_top
  import spt_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Configuration
  input  wire logic              masterMode,
  input  wire logic              clockPhase,
  input  wire logic [DIV_W-1:0]  serialClockDivisor,
  input  wire logic [CD_W-1:0]   coreClockDividerField,
  // User side
  input  wire logic              txStart,
  input  wire logic [WORD_W-1:0] txData,
  output logic      [WORD_W-1:0] rxData,
  output logic                   rxValid,
  output logic                   busy,
  // Serial clock pin
  input  wire logic              sclkIn,
  output logic                   sclkOut,
  output logic                   sclkOe,
  // Slave select pin, active low
  input  wire logic              selectInN,
  output logic                   selectOutN,
  output logic                   selectOe,
  // Data pins: out is MOSI as master and MISO as slave, in the opposite one
  input  wire logic              dataIn,
  output logic                   dataOut,
  output logic                   dataOutOe
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TAIL, ST_SLAVE} spt_state_e;

  spt_tick_if tk ();
  assign tk.cdField = coreClockDividerField;

  spt_core_div u_div (
    .ref_clk (ref_clk),
    .reset   (reset),
    .tk      (tk)
  );

  // Half of one low period in divided clock ticks, never less than one.
  function automatic logic [DIV_W:0] spt_half(input logic [DIV_W-1:0] d);
    logic [DIV_W:0] h;
    h = ({1'b0, d} + 1'b1) >> 1;
    if (h == '0) begin
      h = (DIV_W+1)'(1);
    end
    return h;
  endfunction : spt_half

  // Pin synchronisers: three stages, a change counts once stages two and three agree.
  logic [2:0] s1_r, s2_r, s3_r, filt_r;
  logic [2:0] pins, filt_nxt;

  always_comb begin
    pins = {dataIn, selectInN, sclkIn};
    for (int i = 0; i < 3; i++) begin
      filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_r   <= SYNC_RESET;
      s2_r   <= SYNC_RESET;
      s3_r   <= SYNC_RESET;
      filt_r <= SYNC_RESET;
    end else begin
      s1_r   <= pins;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // Transfer state.
  spt_state_e        state_r, state_nxt;
  logic [DIV_W:0]    cnt_r, cnt_nxt;
  logic [4:0]        edgeCnt_r, edgeCnt_nxt;
  logic [3:0]        bitCnt_r, bitCnt_nxt;
  logic [WORD_W-1:0] txShift_r, txShift_nxt;
  logic [WORD_W-1:0] rxShift_r, rxShift_nxt;
  logic [WORD_W-1:0] rxData_r, rxData_nxt;
  logic              rxValid_r, rxValid_nxt;
  logic              busy_r, busy_nxt;
  logic              sclkOut_r, sclkOut_nxt;
  logic              sclkOe_r, sclkOe_nxt;
  logic              selectOutN_r, selectOutN_nxt;
  logic              selectOe_r, selectOe_nxt;
  logic              dataOut_r, dataOut_nxt;
  logic              dataOutOe_r, dataOutOe_nxt;

  logic              ev, rise, fall, sampleNow, driveNow;
  logic [DIV_W:0]    fullLoad, halfLoad;
  logic [3:0]        bitsAfter;

  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    edgeCnt_nxt    = edgeCnt_r;
    bitCnt_nxt     = bitCnt_r;
    txShift_nxt    = txShift_r;
    rxShift_nxt    = rxShift_r;
    rxData_nxt     = rxData_r;
    rxValid_nxt    = 1'b0;
    busy_nxt       = busy_r;
    sclkOut_nxt    = sclkOut_r;
    sclkOe_nxt     = sclkOe_r;
    selectOutN_nxt = selectOutN_r;
    selectOe_nxt   = selectOe_r;
    dataOut_nxt    = dataOut_r;
    dataOutOe_nxt  = dataOutOe_r;
    fullLoad       = {1'b0, serialClockDivisor};
    halfLoad       = spt_half(serialClockDivisor) - 1'b1;
    ev             = tk.tick && (cnt_r == '0);
    rise           = 1'b0;
    fall           = 1'b0;
    bitsAfter      = bitCnt_r + 1'b1;

    // Serial clock edges come from the own counter as master, from the pin as slave.
    if (state_r == ST_RUN && ev) begin
      rise = ~sclkOut_r;
      fall = sclkOut_r;
    end else if (state_r == ST_SLAVE && filt_nxt[PIN_SEL] == 1'b0) begin
      rise = filt_nxt[PIN_SCLK] && !filt_r[PIN_SCLK];
      fall = !filt_nxt[PIN_SCLK] && filt_r[PIN_SCLK];
    end
    sampleNow = clockPhase ? fall : rise;
    driveNow  = clockPhase ? rise : (fall && bitCnt_r < BITS_PER_WORD);

    if (tk.tick && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end

    // Sampling runs a few reference cycles after the edge behind the synchroniser.
    if (sampleNow) begin
      rxShift_nxt = {rxShift_r[WORD_W-2:0], filt_nxt[PIN_DATA]};
      bitCnt_nxt  = bitsAfter;
      if (bitsAfter == BITS_PER_WORD) begin
        rxData_nxt  = {rxShift_r[WORD_W-2:0], filt_nxt[PIN_DATA]};
        rxValid_nxt = 1'b1;
      end
    end
    // Output bit is registered on the edge cycle itself, well inside the valid window.
    if (driveNow) begin
      dataOut_nxt = txShift_r[WORD_W-1];
      txShift_nxt = {txShift_r[WORD_W-2:0], 1'b0};
    end

    unique case (state_r)
      ST_IDLE: begin
        if (masterMode && txStart) begin
          state_nxt      = ST_RUN;
          busy_nxt       = 1'b1;
          sclkOe_nxt     = 1'b1;
          selectOe_nxt   = 1'b1;
          selectOutN_nxt = 1'b0;
          dataOutOe_nxt  = 1'b1;
          sclkOut_nxt    = SCLK_IDLE;
          edgeCnt_nxt    = '0;
          bitCnt_nxt     = '0;
          cnt_nxt        = halfLoad;
          txShift_nxt    = txData;
          if (!clockPhase) begin
            // First bit leads the first edge by half a low period.
            dataOut_nxt = txData[WORD_W-1];
            txShift_nxt = {txData[WORD_W-2:0], 1'b0};
          end
        end else if (!masterMode && filt_nxt[PIN_SEL] == 1'b0 && filt_r[PIN_SEL] == 1'b1) begin
          // The master frames the word with select low before it clocks.
          state_nxt     = ST_SLAVE;
          busy_nxt      = 1'b1;
          dataOutOe_nxt = 1'b1;
          bitCnt_nxt    = '0;
          txShift_nxt   = txData;
          if (!clockPhase) begin
            // Select low alone puts the first bit out.
            dataOut_nxt = txData[WORD_W-1];
            txShift_nxt = {txData[WORD_W-2:0], 1'b0};
          end
        end
      end
      ST_RUN: begin
        if (ev) begin
          // Each clock phase between the first and last edges lasts divisor plus one divided core clock ticks.
          sclkOut_nxt = ~sclkOut_r;
          edgeCnt_nxt = edgeCnt_r + 1'b1;
          cnt_nxt     = fullLoad;
          if (edgeCnt_r + 1'b1 == EDGES_PER_WORD) begin
            state_nxt = ST_TAIL;
            cnt_nxt   = halfLoad;
          end
        end
      end
      ST_TAIL: begin
        if (ev) begin
          state_nxt      = ST_IDLE;
          busy_nxt       = 1'b0;
          selectOutN_nxt = SELECT_IDLE;
          selectOe_nxt   = 1'b0;
          sclkOe_nxt     = 1'b0;
          dataOutOe_nxt  = 1'b0;
        end
      end
      ST_SLAVE: begin
        // Select going high closes the word and releases the data pin.
        if (filt_nxt[PIN_SEL] == 1'b1) begin
          state_nxt     = ST_IDLE;
          busy_nxt      = 1'b0;
          dataOutOe_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r      <= ST_IDLE;
      cnt_r        <= '0;
      edgeCnt_r    <= '0;
      bitCnt_r     <= '0;
      txShift_r    <= '0;
      rxShift_r    <= '0;
      rxData_r     <= '0;
      rxValid_r    <= 1'b0;
      busy_r       <= 1'b0;
      sclkOut_r    <= SCLK_IDLE;
      sclkOe_r     <= 1'b0;
      selectOutN_r <= SELECT_IDLE;
      selectOe_r   <= 1'b0;
      dataOut_r    <= DATA_IDLE;
      dataOutOe_r  <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      edgeCnt_r    <= edgeCnt_nxt;
      bitCnt_r     <= bitCnt_nxt;
      txShift_r    <= txShift_nxt;
      rxShift_r    <= rxShift_nxt;
      rxData_r     <= rxData_nxt;
      rxValid_r    <= rxValid_nxt;
      busy_r       <= busy_nxt;
      sclkOut_r    <= sclkOut_nxt;
      sclkOe_r     <= sclkOe_nxt;
      selectOutN_r <= selectOutN_nxt;
      selectOe_r   <= selectOe_nxt;
      dataOut_r    <= dataOut_nxt;
      dataOutOe_r  <= dataOutOe_nxt;
    end
  end

  assign rxData     = rxData_r;
  assign rxValid    = rxValid_r;
  assign busy       = busy_r;
  assign sclkOut    = sclkOut_r;
  assign sclkOe     = sclkOe_r;
  assign selectOutN = selectOutN_r;
  assign selectOe   = selectOe_r;
  assign dataOut    = dataOut_r;
  assign dataOutOe  = dataOutOe_r;

endmodule : spt_top

// file: rtl/spt_pkg.sv
// Shared constants for the serial port timing block.
package spt_pkg;

  // Field widths.
  localparam int DIV_W  = 8;
  localparam int CD_W   = 3;
  localparam int WORD_W = 8;
  localparam int SYNC_N = 3;

  // Serial clock edges in one word and the sample count that closes it.
  localparam logic [4:0] EDGES_PER_WORD = 5'h10;
  localparam logic [3:0] BITS_PER_WORD  = 4'h8;

  // Indices into the synchronised pin vector.
  localparam int PIN_SCLK = 0;
  localparam int PIN_SEL  = 1;
  localparam int PIN_DATA = 2;

  // Nominal undivided clock period and the actual reference clock period.
  localparam real UNDIVIDED_PLL_CLOCK_PERIOD_NS    = 48.8;
  localparam int  REF_CLK_PERIOD_NS = 50;
  // One reference clock cycle stands for one undivided clock period.
  localparam int  UNDIVIDED_PLL_CLOCK_CYCLES = (REF_CLK_PERIOD_NS >= UNDIVIDED_PLL_CLOCK_PERIOD_NS) ? 1 : 2;

  // Reset values of the pins and state.
  localparam logic       SCLK_IDLE   = 1'b0;
  localparam logic       SELECT_IDLE = 1'b1;
  localparam logic       DATA_IDLE   = 1'b0;
  localparam logic [2:0] SYNC_RESET  = 3'h7;

endpackage : spt_pkg

// file: rtl/spt_tick_if.sv
// Carries the divider setting in and the divided core clock tick out.
`timescale 1ns/1ps
interface spt_tick_if;
  import spt_pkg::*;
  logic [CD_W-1:0] cdField;
  logic            tick;
  modport gen  (input cdField, output tick);
  modport sink (output cdField, input tick);
endinterface : spt_tick_if

// file: rtl/spt_core_div.sv
// Power-of-two divider that makes the divided core clock tick.
`timescale 1ns/1ps
module spt_core_div
  import spt_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Divider link
  spt_tick_if.gen   tk
);

  localparam int CNT_W = (1 << CD_W) - 1;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             tick_r;
  logic             tick_nxt;
  logic [CNT_W-1:0] mask;

  // The reference clock is the undivided clock; one tick every 2^cd cycles.
  always_comb begin
    mask     = CNT_W'((1 << tk.cdField) - 1);
    tick_nxt = (cnt_r == mask);
    cnt_nxt  = (cnt_r >= mask) ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tk.tick = tick_r;

endmodule : spt_core_div

// file: test/spt_top_asserts.sv
// Timing assertions for the serial port block.
`timescale 1ns/1ps
module spt_top_asserts
  import spt_pkg::*;
(
  // Clock and reset
  input wire logic             ref_clk,
  input wire logic             reset,
  // Configuration
  input wire logic             masterMode,
  input wire logic             clockPhase,
  input wire logic [DIV_W-1:0] serialClockDivisor,
  input wire logic [CD_W-1:0]  coreClockDividerField,
  // Status and pins
  input wire logic             busy,
  input wire logic             sclkOut,
  input wire logic             sclkOe,
  input wire logic             selectInN,
  input wire logic             selectOutN,
  input wire logic             selectOe,
  input wire logic             dataOut,
  input wire logic             dataOutOe
);
  logic [15:0] phaseLen;
  logic [15:0] runLen_r;
  logic [15:0] runLen_nxt;
  logic        sclkLast_r;

  // The run restarts while deselected, so idle time never counts as a low phase.
  assign phaseLen = ({8'h0, serialClockDivisor} + 16'h1) << coreClockDividerField;
  always_comb begin
    runLen_nxt = (sclkOut != sclkLast_r || selectOutN) ? 16'h1 : runLen_r + 16'h1;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclkLast_r <= 1'b0;
      runLen_r   <= 16'h1;
    end else begin
      sclkLast_r <= sclkOut;
      runLen_r   <= runLen_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_mstart;
    masterMode && $rose(busy);
  endsequence
  sequence s_sfall;
    !masterMode && !clockPhase && !busy && $fell(selectInN);
  endsequence

  a_high_width: assert property (
    $fell(sclkOut) && sclkOe |-> runLen_r == phaseLen)
    else $error("clock high phase length wrong");
  a_low_width: assert property (
    $rose(sclkOut) && sclkOe |-> runLen_r <= phaseLen)
    else $error("clock low phase too long");
  a_data_edge: assert property (
    masterMode && busy && $past(busy) && $changed(dataOut) |-> $changed(sclkOut))
    else $error("data moved off a clock edge");
  a_data_setup: assert property (
    masterMode && busy && $changed(sclkOut) && sclkOut != clockPhase |-> $stable(dataOut))
    else $error("data moved on a sampling edge");
  a_master_lead: assert property (
    s_mstart |-> !sclkOut && !selectOutN && selectOe && sclkOe && dataOutOe)
    else $error("frame did not open with clock low");
  a_slave_first: assert property (
    s_sfall |-> ##[1:5] (busy && dataOutOe))
    else $error("slave output late after select");
  a_idle_quiet: assert property (
    !busy |-> !sclkOe && !selectOe && selectOutN && !sclkOut && !dataOutOe)
    else $error("pins driven while idle");
endmodule : spt_top_asserts

bind spt_top spt_top_asserts chk_u (.ref_clk, .reset, .masterMode, .clockPhase,
  .serialClockDivisor, .coreClockDividerField, .busy, .sclkOut, .sclkOe, .selectInN,
  .selectOutN, .selectOe, .dataOut, .dataOutOe);

// file: test/spt_peer.sv
// Behavioural far-side serial peer.
`timescale 1ns/1ps
module spt_peer #(
  parameter int HALF = 6
) (
  // Clock
  input  wire logic ref_clk,
  // Device pins
  input  wire logic clockPhase,
  input  wire logic sclkOut,
  input  wire logic selectOutN,
  input  wire logic dataOut,
  output logic      sclkIn = 1'b0,
  output logic      selectInN = 1'b1,
  output logic      dataIn = 1'b0
);
  logic [7:0] slvTx = 8'h00;
  logic [7:0] slvRx;
  logic [7:0] shift;
  logic       sclkLast;
  logic       selLast;
  int         hold = 0;

  // Slave role: each bit is held three cycles past the sampling edge.
  always @(posedge ref_clk) begin
    sclkLast <= sclkOut;
    selLast  <= selectOutN;
    if (hold > 0) hold <= hold - 1;
    if (hold == 1) begin
      dataIn <= shift[6];
      shift  <= {shift[6:0], 1'b0};
    end
    if (selLast && !selectOutN) begin
      dataIn <= slvTx[7];
      shift  <= slvTx;
    end
    if (!selectOutN && sclkOut != sclkLast && sclkOut != clockPhase) begin
      slvRx <= {slvRx[6:0], dataOut};
      hold  <= 3;
    end
    // A released line shows the inverse so a stale bit never reads as valid.
    if (!selLast && selectOutN) dataIn <= ~dataIn;
  end

  task automatic frame(input logic [7:0] w, output logic [7:0] r);
    int i;
    selectInN <= 1'b0;
    if (!clockPhase) dataIn <= w[7];
    repeat (HALF) @(posedge ref_clk);
    for (i = 7; i >= 0; i--) begin
      if (!clockPhase) r[i] = dataOut;
      sclkIn <= 1'b1;
      if (clockPhase) dataIn <= w[i];
      repeat (HALF) @(posedge ref_clk);
      if (clockPhase) r[i] = dataOut;
      sclkIn <= 1'b0;
      if (!clockPhase && i > 0) dataIn <= w[i-1];
      repeat ((i > 0) ? HALF : HALF / 2) @(posedge ref_clk);
    end
    selectInN <= 1'b1;
    @(posedge ref_clk);
    dataIn <= ~dataIn;
  endtask : frame
endmodule : spt_peer

// file: test/tb.sv
// Self-checking testbench for the serial port block.
`timescale 1ns/1ps
module tb;
  import spt_pkg::*;
  logic              ref_clk = 1'b0, reset = 1'b1, masterMode = 1'b1, clockPhase = 1'b0;
  logic              txStart = 1'b0;
  logic [DIV_W-1:0]  divisor = 8'h09;
  logic [CD_W-1:0]   cdField = 3'h0;
  logic [WORD_W-1:0] txData = 8'h00, rxData, peerRx;
  logic              rxValid, busy, sclkIn, sclkOut, sclkOe, selectInN;
  logic              selectOutN, selectOe, dataIn, dataOut, dataOutOe;
  int                badCount = 0, numChecks = 0, validCount = 0, hiCount = 0, i;
  int                seed = 32'h5f0a995d;

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    validCount <= validCount + rxValid;
    hiCount    <= hiCount + sclkOut;
  end

  spt_top dut_u (.ref_clk, .reset, .masterMode, .clockPhase, .serialClockDivisor(divisor),
    .coreClockDividerField(cdField), .txStart, .txData, .rxData, .rxValid, .busy, .sclkIn,
    .sclkOut, .sclkOe, .selectInN, .selectOutN, .selectOe, .dataIn, .dataOut, .dataOutOe);
  spt_peer peer_u (.ref_clk, .clockPhase, .sclkOut, .selectOutN, .dataOut, .sclkIn,
    .selectInN, .dataIn);

  function automatic logic [15:0] hiCycles(input logic [7:0] d, input logic [2:0] c);
    return 16'(8 * ((d + 1) << c));
  endfunction : hiCycles

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic giveVerdict;
    $display("Checks %0d, mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : giveVerdict

  task automatic doReset;
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk({busy, sclkOe, selectOe, dataOutOe, rxValid, sclkOut, selectOutN, dataOut, rxData},
        16'h0200);
  endtask : doReset

  task automatic master(input logic [7:0] w);
    int n, v0, h0;
    @(posedge ref_clk);
    peer_u.slvTx = 8'($random(seed));
    v0 = validCount;
    h0 = hiCount;
    txStart <= 1'b1;
    txData  <= w;
    @(posedge ref_clk);
    txStart <= 1'b0;
    @(negedge ref_clk);
    chk({11'h0, busy, selectOutN, sclkOe, dataOutOe, clockPhase | dataOut == w[7]}, 16'h17);
    // A start while busy must be ignored.
    repeat (20) @(posedge ref_clk);
    txStart <= 1'b1;
    txData  <= ~w;
    @(posedge ref_clk);
    txStart <= 1'b0;
    for (n = 0; n < 40000 && busy !== 1'b0; n++) @(negedge ref_clk);
    chk(16'(hiCount - h0), hiCycles(divisor, cdField));
    chk({8'h0, peer_u.slvRx}, {8'h0, w});
    chk({8'h0, rxData}, {8'h0, peer_u.slvTx});
    chk(16'(validCount - v0), 16'h1);
  endtask : master

  task automatic slave(input logic [7:0] w, input logic [7:0] d);
    int n, v0;
    txData <= d;
    v0 = validCount;
    @(posedge ref_clk);
    peer_u.frame(w, peerRx);
    for (n = 0; n < 50 && busy !== 1'b0; n++) @(negedge ref_clk);
    chk({8'h0, peerRx}, {8'h0, d});
    chk({8'h0, rxData}, {8'h0, w});
    // A whole word framed by select gives exactly one received-word pulse.
    chk(16'(validCount - v0), 16'h1);
  endtask : slave

  initial begin
    doReset();
    for (i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      clockPhase <= i[0];
      divisor    <= (i == 2) ? 8'hff : 8'h09 + 8'($random(seed) & 7);
      cdField    <= (i < 3) ? 3'h0 : 3'($random(seed) & 3);
      master((i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed)));
    end
    master(8'h5a);
    master(8'ha5);
    @(posedge ref_clk);
    masterMode <= 1'b0;
    txStart    <= 1'b1;
    @(posedge ref_clk);
    txStart <= 1'b0;
    @(negedge ref_clk);
    chk({15'h0, busy}, 16'h0);
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      clockPhase <= i[0];
      slave(8'($random(seed)), (i < 2) ? 8'h81 : 8'($random(seed)));
    end
    @(posedge ref_clk);
    masterMode <= 1'b1;
    txStart    <= 1'b1;
    @(posedge ref_clk);
    txStart <= 1'b0;
    repeat (30) @(posedge ref_clk);
    doReset();
    giveVerdict();
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    badCount++;
    $display("ERROR at %0t: run did not finish", $time);
    giveVerdict();
  end
endmodule : tb
